// File: src/clam_monitor.sv
/*
  clam_monitor: activity flags for the core clock, the transmit test data
  input and 32 receive and transmit links, plus the accumulation trigger
  for the performance counters. Assumes all monitored pins are asynchronous
  to mclk and much slower than it; perf_event comes from mclk logic.
*/
`timescale 1ns/100ps
module clam_monitor #(
  parameter int NCNT = clam_pkg::PERF_COUNT,
  parameter int CW   = clam_pkg::PERF_WIDTH
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire clam_pkg::clam_bus_req_s      bus_req,
  output      clam_pkg::clam_bus_rsp_s      bus_rsp,
  input  wire logic                         core_clock_in,
  input  wire logic                         bert_tx_data_in,
  input  wire logic [clam_pkg::NUM_LINKS-1:0] rx_link_clock,
  input  wire logic [clam_pkg::NUM_LINKS-1:0] rx_link_data,
  input  wire logic [clam_pkg::NUM_LINKS-1:0] tx_link_clock,
  input  wire logic [NCNT-1:0]              perf_event,
  output      logic                         accum_trigger,
  output      logic [NCNT-1:0][CW-1:0]      perf_counters_hold
);

  localparam int NL = clam_pkg::NUM_LINKS;
  localparam int NG = clam_pkg::NUM_GROUPS;
  localparam int GS = clam_pkg::GROUP_SIZE;

  typedef struct packed {
    logic                  core_s1, core_s2, core_prev;
    logic                  bert_s1, bert_s2, bert_prev;
    logic [NL-1:0]         rclk_s1, rclk_s2, rclk_prev;
    logic [NL-1:0]         rd_s1, rd_s2;
    logic [NL-1:0]         tx_link_clock_s1, tx_link_clock_s2, tx_link_clock_prev;
    logic [NL-1:0]         rx_low, rx_high, tx_edge;
    logic                  core_clock_seen, bert_tx_data_seen;
    logic [NG-1:0]         rx_group_seen, tx_group_seen;
    logic [NCNT-1:0][CW-1:0] cnt, hold;
    logic                  accum;
    clam_pkg::clam_bus_rsp_s rsp;
  } clam_state_s;

  clam_state_s st;
  clam_state_s next_st;
  logic        acc_ok, rd_trig, rd_link, wr_trig;
  logic        core_rise, bert_rise;
  logic [NL-1:0] rclk_rise, tx_link_clock_rise;
  logic [NG-1:0] rx_done, tx_done;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  // synchronisers, edge detection, flags, bus decode and counters
  always_comb begin
    next_st = st;
    // two-stage synchronisers; stage one feeds stage two only
    next_st.core_s1   = core_clock_in;
    next_st.core_s2   = st.core_s1;
    next_st.core_prev = st.core_s2;
    next_st.bert_s1   = bert_tx_data_in;
    next_st.bert_s2   = st.bert_s1;
    next_st.bert_prev = st.bert_s2;
    next_st.rclk_s1   = rx_link_clock;
    next_st.rclk_s2   = st.rclk_s1;
    next_st.rclk_prev = st.rclk_s2;
    next_st.rd_s1     = rx_link_data;
    next_st.rd_s2     = st.rd_s1;
    next_st.tx_link_clock_s1   = tx_link_clock;
    next_st.tx_link_clock_s2   = st.tx_link_clock_s1;
    next_st.tx_link_clock_prev = st.tx_link_clock_s2;
    core_rise = st.core_s2 & ~st.core_prev;
    bert_rise = st.bert_s2 & ~st.bert_prev;
    rclk_rise = st.rclk_s2 & ~st.rclk_prev;
    tx_link_clock_rise = st.tx_link_clock_s2 & ~st.tx_link_clock_prev;
    acc_ok  = (bus_req.be_n != clam_pkg::BE_NONE);
    rd_trig = bus_req.rd & acc_ok & (bus_req.addr == clam_pkg::ADDR_TRIGGER);
    rd_link = bus_req.rd & acc_ok & (bus_req.addr == clam_pkg::ADDR_LINK);
    wr_trig = bus_req.wr & acc_ok & (bus_req.addr == clam_pkg::ADDR_TRIGGER);
    // core clock flag: a new edge wins over a read clear
    next_st.core_clock_seen   = core_rise | (st.core_clock_seen & ~rd_trig);
    // test data flag, cleared only by a read
    next_st.bert_tx_data_seen = bert_rise | (st.bert_tx_data_seen & ~rd_trig);
    // receive evidence: data sampled at each link clock rising edge
    next_st.rx_low  = st.rx_low  | (rclk_rise & ~st.rd_s2);
    next_st.rx_high = st.rx_high | (rclk_rise & st.rd_s2);
    // transmit evidence: rising edge per link clock
    next_st.tx_edge = st.tx_edge | tx_link_clock_rise;
    rx_done = '0;
    tx_done = '0;
    for (int g = 0; g < NG; g++) begin
      rx_done[g] = &(next_st.rx_low[g*GS +: GS] & next_st.rx_high[g*GS +: GS]);
      tx_done[g] = &next_st.tx_edge[g*GS +: GS];
      // evidence restarts once its group completion is recorded
      if (rx_done[g]) begin
        next_st.rx_low[g*GS +: GS]  = '0;
        next_st.rx_high[g*GS +: GS] = '0;
      end
      if (tx_done[g]) begin
        next_st.tx_edge[g*GS +: GS] = '0;
      end
    end
    // read clears the whole register; completion in that cycle survives
    next_st.rx_group_seen = rx_done | (st.rx_group_seen & ~{NG{rd_link}});
    next_st.tx_group_seen = tx_done | (st.tx_group_seen & ~{NG{rd_link}});
    // read data layout, unused bits zero
    next_st.rsp.rvalid = bus_req.rd;
    next_st.rsp.rdata  = clam_pkg::RDATA_IDLE;
    if (rd_trig) begin
      next_st.rsp.rdata[clam_pkg::CORE_SEEN_BIT] = st.core_clock_seen;
      next_st.rsp.rdata[clam_pkg::BERT_SEEN_BIT] = st.bert_tx_data_seen;
    end else if (rd_link) begin
      next_st.rsp.rdata[clam_pkg::RX_GROUP_LSB +: NG] = st.rx_group_seen;
      next_st.rsp.rdata[clam_pkg::TX_GROUP_LSB +: NG] = st.tx_group_seen;
    end
    next_st.accum = wr_trig;
    for (int c = 0; c < NCNT; c++) begin
      if (wr_trig) begin
        // copy then restart, counting this cycle's event
        next_st.hold[c] = st.cnt[c];
        next_st.cnt[c]  = {{(CW-1){1'b0}}, perf_event[c]};
      end else begin
        next_st.cnt[c]  = st.cnt[c] + {{(CW-1){1'b0}}, perf_event[c]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // whole state clears on reset; flags start low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign bus_rsp            = st.rsp;
  assign accum_trigger      = st.accum;
  assign perf_counters_hold = st.hold;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_trig_write;
    bus_req.wr && bus_req.be_n != clam_pkg::BE_NONE && bus_req.addr == clam_pkg::ADDR_TRIGGER;
  endsequence

  sequence s_trig_read;
    bus_req.rd && bus_req.be_n != clam_pkg::BE_NONE && bus_req.addr == clam_pkg::ADDR_TRIGGER;
  endsequence

  sequence s_link_read;
    bus_req.rd && bus_req.be_n != clam_pkg::BE_NONE && bus_req.addr == clam_pkg::ADDR_LINK;
  endsequence

  a_core_edge_sets: assert property (core_rise |=> st.core_clock_seen)
    else $error("core clock edge did not set its flag");
  a_bert_edge_sets: assert property (bert_rise |=> st.bert_tx_data_seen)
    else $error("test data edge did not set its flag");
  a_flag_holds_high: assert property (st.core_clock_seen && !bus_req.rd |=> st.core_clock_seen)
    else $error("activity flag dropped without a read");
  a_read_clears_all: assert property (s_trig_read ##0 !core_rise && !bert_rise
                                      |=> !st.core_clock_seen && !st.bert_tx_data_seen)
    else $error("read did not clear trigger register flags");
  a_link_read_clears: assert property (s_link_read ##0 rx_done == '0 && tx_done == '0
                                       |=> st.rx_group_seen == '0 && st.tx_group_seen == '0)
    else $error("read did not clear link register flags");
  a_read_answers: assert property (bus_req.rd |=> bus_rsp.rvalid)
    else $error("read strobe got no answer");
  a_read_returns_flag: assert property (s_trig_read ##0 st.core_clock_seen
                                        |=> bus_rsp.rvalid && bus_rsp.rdata[0])
    else $error("read lost a set flag");
  a_none_no_access: assert property (bus_req.be_n == clam_pkg::BE_NONE && st.core_clock_seen
                                     |=> !accum_trigger && st.core_clock_seen)
    else $error("access with no byte enables had an effect");
  a_write_pulses: assert property (s_trig_write |=> accum_trigger ##1 !accum_trigger || $past(wr_trig))
    else $error("trigger write did not pulse accumulation");
  a_hold_copy: assert property (s_trig_write |=> perf_counters_hold[0] == $past(st.cnt[0]))
    else $error("holding register missed counter value");
  a_cnt_restart: assert property (s_trig_write |=> st.cnt[0] == {{(CW-1){1'b0}}, $past(perf_event[0])})
    else $error("counter did not restart");
  a_write_keeps_flags: assert property (s_trig_write ##0 st.core_clock_seen |=> st.core_clock_seen)
    else $error("write changed an activity flag");
  a_rx_group_sets: assert property (rx_done[1] |=> st.rx_group_seen[1] && st.rx_low[7:4] == 4'h0)
    else $error("receive group completion not recorded");
  a_tx_group_needs_all: assert property ($rose(st.tx_group_seen[4])
                                         |-> $past(&next_st.tx_edge[19:16]) || $past(tx_done[4]))
    else $error("transmit group set without all edges");
  a_unused_zero: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:16] == 16'h0000)
    else $error("unused bits read nonzero");
  a_idle_rdata_zero: assert property (!bus_rsp.rvalid |-> bus_rsp.rdata == 32'h0000_0000)
    else $error("read data nonzero outside an answer");
  a_link_write_ignored: assert property (bus_req.wr && bus_req.addr == clam_pkg::ADDR_LINK
                                         |=> !accum_trigger)
    else $error("write to link register had an effect");

endmodule : clam_monitor

// File: src/clam_pkg.sv
/*
  clam_pkg: constants and carrier types for the clock and link activity
  monitor. Assumes a host register port with active-low byte enables and
  12-bit byte addresses.
*/
package clam_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_TRIGGER   = 12'h00C;  // clock/data activity, accumulation trigger
  localparam logic [11:0] ADDR_LINK      = 12'h010;  // link group activity
  localparam logic [3:0]  BE_NONE        = 4'hF;     // all byte enables negated
  localparam int          CORE_SEEN_BIT  = 0;
  localparam int          BERT_SEEN_BIT  = 1;
  localparam int          RX_GROUP_LSB   = 0;
  localparam int          TX_GROUP_LSB   = 8;
  localparam logic [31:0] RDATA_IDLE     = 32'h0000_0000;  // unused bits and unmapped reads

  // ----------------------------------------------------------------------
  // link structure and reset values
  // ----------------------------------------------------------------------
  localparam int          NUM_LINKS      = 32;
  localparam int          GROUP_SIZE     = 4;
  localparam int          NUM_GROUPS     = 8;
  localparam int          PERF_COUNT     = 4;
  localparam int          PERF_WIDTH     = 16;
  localparam logic        FLAG_RESET     = 1'b0;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        rd;    // one-cycle read strobe
    logic        wr;    // one-cycle write strobe
    logic [11:0] addr;  // byte address
    logic [3:0]  be_n;  // byte enables, active low
  } clam_bus_req_s;

  typedef struct packed {
    logic        rvalid;  // one-cycle read answer
    logic [31:0] rdata;
  } clam_bus_rsp_s;

endpackage : clam_pkg

// File: tb/clam_monitor_tb_top.sv
/*
  clam_monitor_tb_top: self-checking bench for the clock and link activity
  monitor. Assumes clam_pkg and clam_monitor are compiled before it.
*/
`timescale 1ns/100ps
module clam_monitor_tb_top;
  logic                    mclk;
  logic                    rst_n;
  clam_pkg::clam_bus_req_s bus_req;
  clam_pkg::clam_bus_rsp_s bus_rsp;
  logic                    core_clock_in;
  logic                    bert_tx_data_in;
  logic [31:0]             rx_link_clock;
  logic [31:0]             rx_link_data;
  logic [31:0]             tx_link_clock;
  logic [3:0]              perf_event;
  logic                    accum_trigger;
  logic [3:0][15:0]        perf_counters_hold;
  int                      error_cnt;
  int                      n_checks;

  clam_monitor dut (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .bus_req            (bus_req),
    .bus_rsp            (bus_rsp),
    .core_clock_in      (core_clock_in),
    .bert_tx_data_in    (bert_tx_data_in),
    .rx_link_clock      (rx_link_clock),
    .rx_link_data       (rx_link_data),
    .tx_link_clock      (tx_link_clock),
    .perf_event         (perf_event),
    .accum_trigger      (accum_trigger),
    .perf_counters_hold (perf_counters_hold)
  );

  // ----------------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // cut a hang short well past the expected run length
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // one read strobe, answer sampled one cycle later
  task automatic rd(input logic [11:0] addr, input logic [3:0] be_n, input logic [31:0] exp);
    @(negedge mclk);
    bus_req <= {1'b1, 1'b0, addr, be_n};
    @(negedge mclk);
    bus_req.rd <= 1'b0;
    chk({63'h0, bus_rsp.rvalid}, 64'h1, "read answer");
    chk({32'h0, bus_rsp.rdata}, {32'h0, exp}, "read data");
  endtask : rd

  // one write strobe, trigger pulse sampled one cycle later
  task automatic wr(input logic [11:0] addr, input logic [3:0] be_n, input logic exp_trig);
    @(negedge mclk);
    bus_req <= {1'b0, 1'b1, addr, be_n};
    @(negedge mclk);
    bus_req.wr <= 1'b0;
    chk({63'h0, accum_trigger}, {63'h0, exp_trig}, "trigger pulse");
  endtask : wr

  // slow pulses on the core clock and test data pins
  task automatic pins(input logic [1:0] sel);
    repeat (2) begin
      @(negedge mclk);
      {bert_tx_data_in, core_clock_in} <= sel;
      repeat (4) @(negedge mclk);
      {bert_tx_data_in, core_clock_in} <= 2'b00;
      repeat (4) @(negedge mclk);
    end
  endtask : pins

  // link clocks of 125 ns; receive data changes only on falling link edges
  task automatic link_burst(input logic [31:0] rxm, input logic [31:0] txm);
    // non-blocking, so a link edge landing on an mclk rise never races the sampler
    for (int i = 0; i < 6; i++) begin
      rx_link_clock <= 32'h0000_0000;
      tx_link_clock <= 32'h0000_0000;
      rx_link_data  <= i[0] ? rxm : 32'h0000_0000;
      #62.5;
      rx_link_clock <= rxm;
      tx_link_clock <= txm;
      #62.5;
    end
    rx_link_clock <= 32'h0000_0000;
    tx_link_clock <= 32'h0000_0000;
    rx_link_data  <= 32'h0000_0000;
  endtask : link_burst

  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    bus_req = '0;
    {core_clock_in, bert_tx_data_in, perf_event} = '0;
    {rx_link_clock, rx_link_data, tx_link_clock} = '0;
    repeat (6) @(negedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(negedge mclk);
    rd(clam_pkg::ADDR_TRIGGER, 4'h0, 32'h0000_0000);
    rd(clam_pkg::ADDR_LINK, 4'h0, 32'h0000_0000);
    // interval one: event counts of 5, 4, 4 and 2 on counters 0 to 3
    for (int c = 0; c < 10; c++) begin
      @(negedge mclk);
      perf_event <= 4'(c);
    end
    @(negedge mclk);
    perf_event <= 4'h0;
    wr(clam_pkg::ADDR_TRIGGER, 4'h0, 1'b1);
    chk(perf_counters_hold, 64'h0002_0004_0004_0005, "hold one");
    repeat (3) begin
      @(negedge mclk);
      perf_event <= 4'h3;
    end
    @(negedge mclk);
    perf_event <= 4'h0;
    wr(clam_pkg::ADDR_TRIGGER, clam_pkg::BE_NONE, 1'b0);
    chk(perf_counters_hold, 64'h0002_0004_0004_0005, "hold kept");
    wr(clam_pkg::ADDR_TRIGGER, 4'h0, 1'b1);
    chk(perf_counters_hold, 64'h0000_0000_0003_0003, "hold two");
    // core clock activity survives a write and a no-access read
    pins(2'b01);
    wr(clam_pkg::ADDR_TRIGGER, 4'h0, 1'b1);
    rd(clam_pkg::ADDR_TRIGGER, clam_pkg::BE_NONE, 32'h0000_0000);
    rd(clam_pkg::ADDR_TRIGGER, 4'hE, 32'h0000_0001);
    rd(clam_pkg::ADDR_TRIGGER, 4'h0, 32'h0000_0000);
    pins(2'b10);
    rd(clam_pkg::ADDR_TRIGGER, 4'h7, 32'h0000_0002);
    rd(clam_pkg::ADDR_TRIGGER, 4'h0, 32'h0000_0000);
    // receive group 1 full, transmit group 4 full, transmit group 0 short one link
    link_burst(32'h0000_00F0, 32'h000F_0007);
    repeat (8) @(negedge mclk);
    wr(clam_pkg::ADDR_LINK, 4'h0, 1'b0);
    rd(clam_pkg::ADDR_LINK, 4'h0, 32'h0000_1002);
    rd(clam_pkg::ADDR_LINK, 4'h0, 32'h0000_0000);
    // receive group 0 alone, transmit group 7 alone
    link_burst(32'h0000_000F, 32'hF000_0000);
    repeat (8) @(negedge mclk);
    rd(clam_pkg::ADDR_LINK, 4'hC, 32'h0000_8001);
    rd(12'h014, 4'h0, 32'h0000_0000);
    rd(clam_pkg::ADDR_LINK, 4'h0, 32'h0000_0000);
    test_done();
  end

endmodule : clam_monitor_tb_top
